// *** bench/lsira_conv_model.sv ***
// Purpose: Converter model that drives the measurement link
// Assumes: Link clock idles low between frames
// Notes: Data is inverted once it is released
`timescale 1ns/1ps
module lsira_conv_model
	import lsira_pkg::*;
(
	output logic conv_clk,
	output logic conv_done,
	output lsira_meas_s conv_meas
);
	// Link is idle at time zero
	initial begin
		conv_clk = 1'b0;
		conv_done = 1'b0;
		conv_meas = '0;
	end
	// One frame: two link rises, done high for the first one only
	task automatic convert(input logic ch, input logic ovf, input logic [19:0] mant);
		#1 conv_meas = {ovf, ch, mant};
		conv_done = 1'b1;
		#62.5 conv_clk = 1'b1;
		#62.5 conv_clk = 1'b0;
		conv_done = 1'b0;
		#62.5 conv_clk = 1'b1;
		#62.5 conv_clk = 1'b0;
		conv_meas = ~conv_meas; // Released data must not look valid
	endtask : convert
endmodule : lsira_conv_model

// *** bench/lsira_core_monitor.sv ***
// Purpose: Port checks for the interrupt and range core
// Assumes: Bound to every core instance
// Notes: Pin is active when oe differs from polarity
`timescale 1ns/1ps
module lsira_monitor (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic irq_pin_polarity,
	input wire logic latch_style,
	input wire logic [1:0] pin_function,
	input wire logic [3:0] range_sel,
	input wire logic flag_reg_read,
	input wire logic irq_out,
	input wire logic irq_oe,
	input wire logic flag_high,
	input wire logic flag_low,
	input wire logic [3:0] visible_channel_exp,
	input wire logic [3:0] infrared_channel_exp,
	input wire logic restart_req,
	input wire logic result_valid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	wire pin_act = irq_oe ^ irq_pin_polarity; // Pin at its active level
	property p_odata; irq_out == 1'b0; endproperty
	a_odata: assert property (p_odata) else $error("pin data high");
	property p_hhi; !latch_style && $rose(flag_high) |-> !flag_low && result_valid; endproperty
	a_hhi: assert property (p_hhi) else $error("high flag set badly");
	property p_hlo; !latch_style && $rose(flag_low) |-> !flag_high && result_valid; endproperty
	a_hlo: assert property (p_hlo) else $error("low flag set badly");
	property p_hold; latch_style && ($fell(flag_high) || $fell(flag_low))
		|-> $past(flag_reg_read); endproperty
	a_hold: assert property (p_hold) else $error("flag cleared without read");
	property p_upd; ($changed(flag_high) || $changed(flag_low)) && !$past(flag_reg_read)
		|-> result_valid; endproperty
	a_upd: assert property (p_upd) else $error("flag moved off a result");
	property p_hpin; !latch_style && pin_function == 2'h0 && $stable(irq_pin_polarity)
		&& !$past(reset) |-> pin_act == flag_high; endproperty
	a_hpin: assert property (p_hpin) else $error("pin differs from flag");
	property p_pst; pin_function != 2'h0 && $rose(pin_act) && $stable(irq_pin_polarity)
		|-> result_valid; endproperty
	a_pst: assert property (p_pst) else $error("pulse without result");
	property p_rng; range_sel <= 4'h8 |=> visible_channel_exp == $past(range_sel)
		&& infrared_channel_exp == ($past(range_sel) > 4'h6 ? 4'h6 : $past(range_sel));
	endproperty
	a_rng: assert property (p_rng) else $error("manual range wrong");
	property p_excl; !(result_valid && restart_req); endproperty
	a_excl: assert property (p_excl) else $error("aborted result published");
	property p_rst; restart_req
		|-> $changed(visible_channel_exp) || $changed(infrared_channel_exp); endproperty
	a_rst: assert property (p_rst) else $error("restart without range step");
endmodule : lsira_monitor
bind lsira_core lsira_monitor i_mon (
	.ref_clk(ref_clk), .reset(reset), .irq_pin_polarity(irq_pin_polarity),
	.latch_style(latch_style), .pin_function(pin_function), .range_sel(range_sel),
	.flag_reg_read(flag_reg_read), .irq_out(irq_out), .irq_oe(irq_oe),
	.flag_high(flag_high), .flag_low(flag_low), .visible_channel_exp(visible_channel_exp),
	.infrared_channel_exp(infrared_channel_exp), .restart_req(restart_req),
	.result_valid(result_valid)
);

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the interrupt and range core
// Assumes: Converter model drives the link
// Notes: Pin pulse shortened to five cycles
`timescale 1ns/1ps
module tb;
	import lsira_pkg::*;
	localparam int PULSE = 5; // Short pin pulse
	localparam logic [19:0] HI = 20'h0_2000, MID = 20'h0_0800, LO = 20'h0_0080; // Around limits
	localparam logic [19:0] AM [5] = '{20'h0_f000, 20'h0_0000, 20'h0_f000, 20'h0_3000, MID};
	localparam logic AOV [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0}; // Second one overflows
	localparam logic [3:0] AEX [5] = '{4'h1, 4'h2, 4'h3, 4'h2, 4'h0}; // Next visible range
	logic ref_clk, reset, irq_pin_polarity, latch_style, flag_reg_read, conv_clk, conv_done;
	logic [1:0] fault_count, pin_function;
	logic [3:0] range_sel, visible_channel_exp, infrared_channel_exp;
	logic irq_out, irq_oe, flag_high, flag_low, restart_req, result_valid;
	logic act_d = 1'b0; // Pin activity at the previous edge
	lsira_meas_s conv_meas;
	lsira_result_s result;
	int errors, n_tests, n_pulse, n_act, n_valid, n_restart;
	int b_pulse, b_act, b_valid, b_rst; // Counts at the start of a scenario
	wire pin_act = ((irq_oe ? 1'b0 : 1'b1) == irq_pin_polarity); // Pulled-up wire is active
	wire [2:0] fl = {flag_high, flag_low, pin_act}; // Interrupt state seen together
	lsira_conv_model i_model (.conv_clk(conv_clk), .conv_done(conv_done), .conv_meas(conv_meas));
	lsira_core #(.PULSE_CYC(PULSE)) i_dut (
		.ref_clk(ref_clk), .reset(reset), .conv_clk(conv_clk), .conv_done(conv_done),
		.conv_meas(conv_meas), .irq_pin_polarity(irq_pin_polarity), .latch_style(latch_style),
		.fault_count(fault_count), .pin_function(pin_function), .range_sel(range_sel),
		.thr_channel(1'b0), .limit_high({12'h010, 4'h0}), .limit_low({12'h001, 4'h0}),
		.flag_reg_read(flag_reg_read), .irq_out(irq_out), .irq_oe(irq_oe),
		.flag_high(flag_high), .flag_low(flag_low), .visible_channel_exp(visible_channel_exp),
		.infrared_channel_exp(infrared_channel_exp), .restart_req(restart_req),
		.result_valid(result_valid), .result(result)
	);
	// Reference clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Count pulses, active cycles and strobes
	always @(posedge ref_clk) begin
		n_pulse += (pin_act && !act_d);
		n_act += pin_act;
		n_valid += result_valid;
		n_restart += restart_req;
		act_d <= pin_act;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic end_sim;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_sim
	// Run n conversions of one value
	task automatic conv(input logic [19:0] m, input int n, input logic ch = 1'b0,
		input logic ov = 1'b0);
		repeat (n) begin
			i_model.convert(ch, ov, m);
			@(negedge ref_clk);
		end
	endtask : conv
	// Status read strobe, then let the clear land
	task automatic rd_flags;
		flag_reg_read = 1'b1;
		@(negedge ref_clk);
		flag_reg_read = 1'b0;
		repeat (2) @(negedge ref_clk);
	endtask : rd_flags
	// Main sequence
	initial begin
		{reset, irq_pin_polarity, latch_style, flag_reg_read} = 4'hc;
		fault_count = 2'h2;
		pin_function = 2'h0;
		range_sel = 4'hc;
		repeat (5) @(negedge ref_clk);
		reset = 1'b0;
		repeat (4) @(negedge ref_clk);
		// Hysteresis, four faults needed, broken run restarts
		conv(HI, 3);
		conv(MID, 1);
		conv(HI, 3);
		check(fl, 3'h0);
		conv(HI, 1);
		check(fl, 3'h5);
		conv(MID, 1);
		check(fl, 3'h5);
		conv(LO, 4);
		check(fl, 3'h2);
		conv(HI, 4);
		check(fl, 3'h5);
		// Window style, single fault
		latch_style = 1'b1;
		fault_count = 2'h0;
		rd_flags();
		check(fl, 3'h0);
		conv(LO, 1);
		conv(MID, 1);
		check(fl, 3'h3);
		conv(HI, 1);
		check(fl, 3'h7);
		rd_flags();
		check(fl, 3'h0);
		// Pulse modes on an active-low pin
		latch_style = 1'b0;
		irq_pin_polarity = 1'b0;
		repeat (2) @(negedge ref_clk);
		for (int f = 1; f < 4; f++) begin
			pin_function = f[1:0];
			b_pulse = n_pulse;
			b_act = n_act;
			conv(HI, 4);
			check(n_pulse - b_pulse, 4 / f);
			check(n_act - b_act, (4 / f) * PULSE);
		end
		check(fl[2], 1'b1);
		// Automatic ranging with two overflows, one restarted
		b_valid = n_valid;
		b_rst = n_restart;
		for (int i = 0; i < 5; i++) begin
			conv(AM[i], 1, 1'b0, AOV[i]);
			check(visible_channel_exp, AEX[i]);
		end
		check(n_valid - b_valid, 4);
		check(result, {1'b0, 4'h2, MID});
		conv(20'h0_f000, 1, 1'b1);
		check({visible_channel_exp, infrared_channel_exp}, 8'h01);
		conv(20'h0_f000, 5, 1'b1);
		check(infrared_channel_exp, IR_EXP_MAX);
		conv(HI, 1, 1'b1, 1'b1);
		check(n_valid - b_valid, 10);
		check(n_restart - b_rst, 1);
		// Manual ranges
		for (int v = 0; v < 9; v++) begin
			range_sel = v[3:0];
			repeat (2) @(negedge ref_clk);
			check({visible_channel_exp, infrared_channel_exp}, {v[3:0], v > 6 ? 4'h6 : v[3:0]});
		end
		conv(HI, 1, 1'b0, 1'b1);
		check({visible_channel_exp, 4'(n_restart - b_rst)}, 8'h81);
		end_sim();
	end
	// Watchdog
	initial begin
		#60000;
		errors++;
		end_sim();
	end
endmodule : tb

// *** common/lsira_pkg.sv ***
// Purpose: Shared constants and types for the light sensor interrupt and autorange block
// Assumes: 200 MHz reference clock
// Notes: Exponents follow the linear code = mantissa << exponent convention
package lsira_pkg;
	// Clock and pulse timing
	localparam int CLK_MHZ = 200;
	localparam int IRQ_PULSE_NS = 1000;
	localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ + 999) / 1000;
	// Field widths
	localparam int MANT_W = 20;
	localparam int THR_W = 12;
	localparam int EXP_W = 4;
	localparam int LIN_W = 36;
	// Range encodings
	localparam logic [3:0] RANGE_AUTO = 4'h000c;
	localparam logic [3:0] VIS_EXP_MAX = 4'h0008;
	localparam logic [3:0] IR_EXP_MAX = 4'h0006;
	localparam logic [3:0] THR_SHIFT_BASE = 4'h0008;
	// Autorange decision points and manual-overflow saturation value on the mantissa
	localparam logic [19:0] MANT_FULL = 20'h0_ffff;
	localparam logic [19:0] MANT_HIGH = 20'h0_e000;
	localparam logic [19:0] MANT_LOW1 = 20'h0_4000;
	localparam logic [19:0] MANT_LOW2 = 20'h0_1000;
	// Reset values
	localparam logic [3:0] EXP_RST = 4'h0000;
	localparam logic [3:0] FAULT_RST = 4'h0000;
	// Interrupt pin functions
	localparam logic [1:0] PIN_FAULT = 2'h0;
	localparam logic [1:0] PIN_EOC = 2'h1;
	localparam logic [1:0] PIN_PAIR = 2'h2;
	localparam logic [1:0] PIN_QUAD = 2'h3;

	// One conversion result as delivered by the converter
	typedef struct packed {
		logic ovf; // Result overflowed its range
		logic ch; // 0 visible, 1 infrared
		logic [19:0] mant; // Linear mantissa
	} lsira_meas_s;

	// One limit: mantissa and exponent
	typedef struct packed {
		logic [11:0] mant;
		logic [3:0] expo;
	} lsira_limit_s;

	// Published result
	typedef struct packed {
		logic ch;
		logic [3:0] expo;
		logic [19:0] mant;
	} lsira_result_s;
endpackage : lsira_pkg

// *** hw/lsira_core.sv ***
// Purpose: Limit comparison, fault counting, interrupt pin and automatic range control
// Assumes: Converter holds its result stable across several conv_clk periods
// Notes: All converter-side inputs are synchronised and sampled on ref_clk rising edges
`timescale 1ns/1ps
module lsira_core
	import lsira_pkg::*;
#(
	parameter int PULSE_CYC = IRQ_PULSE_CYC
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic conv_clk,
	input wire logic conv_done,
	input wire lsira_meas_s conv_meas,
	input wire logic irq_pin_polarity,
	input wire logic latch_style,
	input wire logic [1:0] fault_count,
	input wire logic [1:0] pin_function,
	input wire logic [3:0] range_sel,
	input wire logic thr_channel,
	input wire lsira_limit_s limit_high,
	input wire lsira_limit_s limit_low,
	input wire logic flag_reg_read,
	output logic irq_out,
	output logic irq_oe,
	output logic flag_high,
	output logic flag_low,
	output logic [3:0] visible_channel_exp,
	output logic [3:0] infrared_channel_exp,
	output logic restart_req,
	output logic result_valid,
	output lsira_result_s result
);
	// Linear code of a mantissa shifted by an amount
	function automatic logic [LIN_W-1:0] lin_code(input logic [LIN_W-1:0] m, input logic [4:0] sh);
		lin_code = m << sh;
	endfunction : lin_code

	// Consecutive faults needed for a fault setting
	// Setting n asks for two to the power n faults in a row
	function automatic logic [3:0] fault_need(input logic [1:0] fc);
		fault_need = 4'h0001 << fc;
	endfunction : fault_need

	// Synchronisers for all converter-side inputs
	// The result word is synchronised bit by bit. That is safe only because the
	// converter holds it steady from before done rises until after done falls,
	// so every bit has settled long before the link edge that takes it.
	logic clk_s1_r, clk_s2_r, clk_s3_r; // Link clock stages, s3 for edge
	logic done_s1_r, done_s2_r; // Conversion done stages
	lsira_meas_s meas_s1_r, meas_s2_r; // Result stages

	// Two-flop synchroniser, third flop only for edge detect on the clean copy
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			clk_s3_r <= 1'b0;
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			meas_s1_r <= '0;
			meas_s2_r <= '0;
		end else begin
			clk_s1_r <= conv_clk;
			clk_s2_r <= clk_s1_r;
			clk_s3_r <= clk_s2_r;
			done_s1_r <= conv_done;
			done_s2_r <= done_s1_r;
			meas_s1_r <= conv_meas;
			meas_s2_r <= meas_s1_r;
		end
	end

	// A done level that spans several link edges must count as one conversion,
	// so the event needs done high now and low at the previous link edge.
	// The link clock is only sampled, never used as a clock, so the whole
	// block stays in the ref_clk domain.
	// Conversion seen on a rising link clock edge while done is high
	logic done_prev_r; // Done level at previous link edge, one event per done
	wire link_rise = clk_s2_r & ~clk_s3_r;
	wire conv_evt = link_rise & done_s2_r & ~done_prev_r;

	// Remember done at each link edge so a long done gives one event
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			done_prev_r <= 1'b0;
		end else if (link_rise) begin
			done_prev_r <= done_s2_r;
		end
	end

	// Range state
	logic [3:0] vis_exp_r, vis_exp_nxt; // Visible channel exponent
	logic [3:0] ir_exp_r, ir_exp_nxt; // Infrared channel exponent
	wire auto_mode = (range_sel == RANGE_AUTO);
	wire is_ir = meas_s2_r.ch;
	wire [3:0] cur_exp = is_ir ? ir_exp_r : vis_exp_r;
	// Each channel has its own top range
	wire [3:0] cur_max = is_ir ? IR_EXP_MAX : VIS_EXP_MAX;
	wire at_top = (cur_exp >= cur_max);
	// In automatic mode an overflowed result is always dropped. Below the top
	// range the converter is also told to step up and measure again; at the
	// top there is nothing higher to try, so that result is simply lost.
	// Manual mode cannot change range, so its overflow is published saturated.
	wire drop = conv_evt & meas_s2_r.ovf & auto_mode;
	wire abort = drop & ~at_top;
	wire publish = conv_evt & ~drop;
	// Manual exponents, infrared capped
	wire [3:0] man_vis = (range_sel > VIS_EXP_MAX) ? VIS_EXP_MAX : range_sel;
	wire [3:0] man_ir = (man_vis > IR_EXP_MAX) ? IR_EXP_MAX : man_vis;
	// Saturated mantissa for an overflow taken in manual mode
	wire [19:0] pub_mant = meas_s2_r.ovf ? MANT_FULL : meas_s2_r.mant;

	// Thresholds sit on the mantissa alone: near full scale step up one range,
	// well below it step down one, and far below it step down two. The steps
	// saturate at range zero and at the channel's top range.
	// Autorange step for the measured channel
	logic [3:0] auto_exp;
	always_comb begin
		auto_exp = cur_exp;
		if (meas_s2_r.ovf) begin
			auto_exp = at_top ? cur_exp : cur_exp + 4'h0001;
		end else if (pub_mant >= MANT_HIGH) begin
			auto_exp = at_top ? cur_exp : cur_exp + 4'h0001;
		end else if (pub_mant < MANT_LOW2) begin
			auto_exp = (cur_exp >= 4'h0002) ? cur_exp - 4'h0002 : EXP_RST;
		end else if (pub_mant < MANT_LOW1) begin
			auto_exp = (cur_exp >= 4'h0001) ? cur_exp - 4'h0001 : EXP_RST;
		end
	end

	// Manual values are reloaded every cycle, so leaving automatic mode takes
	// effect at once. In automatic mode only the channel just measured moves.
	always_comb begin
		vis_exp_nxt = vis_exp_r;
		ir_exp_nxt = ir_exp_r;
		if (!auto_mode) begin
			vis_exp_nxt = man_vis;
			ir_exp_nxt = man_ir;
		end else if (conv_evt) begin
			if (is_ir) begin
				ir_exp_nxt = auto_exp;
			end else begin
				vis_exp_nxt = auto_exp;
			end
		end
	end

	// Range registers
	// Both channels start at the lowest range after reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			vis_exp_r <= EXP_RST;
			ir_exp_r <= EXP_RST;
		end else begin
			vis_exp_r <= vis_exp_nxt;
			ir_exp_r <= ir_exp_nxt;
		end
	end

	// Both sides are brought to the same linear scale before comparing. The
	// limit mantissa starts eight places up, so a 12-bit limit lines up with
	// the top bits of a full-range result. Comparisons are strict.
	// Limit comparison on the selected channel
	wire [LIN_W-1:0] meas_lin = lin_code(LIN_W'(pub_mant), {1'b0, cur_exp});
	wire [LIN_W-1:0] hi_lin = lin_code(LIN_W'(limit_high.mant),
		{1'b0, limit_high.expo} + {1'b0, THR_SHIFT_BASE});
	wire [LIN_W-1:0] lo_lin = lin_code(LIN_W'(limit_low.mant),
		{1'b0, limit_low.expo} + {1'b0, THR_SHIFT_BASE});
	wire cmp_evt = publish & (meas_s2_r.ch == thr_channel);
	wire above = meas_lin > hi_lin;
	wire below = meas_lin < lo_lin;

	// Each direction keeps its own run length. A result that does not break
	// that limit clears the run, so only unbroken runs qualify. The tally stops
	// at the needed count so it cannot wrap during a long excursion.
	// Consecutive fault tallies
	logic [3:0] hi_cnt_r, hi_cnt_nxt; // Consecutive faults above
	logic [3:0] lo_cnt_r, lo_cnt_nxt; // Consecutive faults below
	wire [3:0] need = fault_need(fault_count);
	wire hi_sat = (hi_cnt_r >= need);
	wire lo_sat = (lo_cnt_r >= need);
	assign hi_cnt_nxt = !above ? FAULT_RST : (hi_sat ? hi_cnt_r : hi_cnt_r + 4'h0001);
	assign lo_cnt_nxt = !below ? FAULT_RST : (lo_sat ? lo_cnt_r : lo_cnt_r + 4'h0001);
	// Qualified events use the tally including this measurement
	wire hi_fault = cmp_evt & above & (hi_cnt_nxt >= need);
	wire lo_fault = cmp_evt & below & (lo_cnt_nxt >= need);

	// Tally registers update on each compared result
	// Results of the other channel leave both tallies alone
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			hi_cnt_r <= FAULT_RST;
			lo_cnt_r <= FAULT_RST;
		end else if (cmp_evt) begin
			hi_cnt_r <= hi_cnt_nxt;
			lo_cnt_r <= lo_cnt_nxt;
		end
	end

	// Hysteresis never latches: each qualified fault simply overwrites the
	// state. Window style only ever sets; the status read is the one way out.
	// A fault and a read in the same cycle leave the state set, so no fault
	// is lost to a read that raced it.
	// Flags and fault-pin state
	logic flag_h_r, flag_h_nxt; // Above-high flag
	logic flag_l_r, flag_l_nxt; // Below-low flag
	logic fault_act_r, fault_act_nxt; // Fault-driven pin activity
	always_comb begin
		flag_h_nxt = flag_h_r;
		flag_l_nxt = flag_l_r;
		fault_act_nxt = fault_act_r;
		if (!latch_style) begin
			// Hysteresis: no latching, each qualified fault decides
			if (hi_fault) begin
				flag_h_nxt = 1'b1;
				flag_l_nxt = 1'b0;
				fault_act_nxt = 1'b1;
			end else if (lo_fault) begin
				flag_h_nxt = 1'b0;
				flag_l_nxt = 1'b1;
				fault_act_nxt = 1'b0;
			end
		end else begin
			// Window: status read clears, a new fault in the same cycle wins
			if (flag_reg_read) begin
				flag_h_nxt = 1'b0;
				flag_l_nxt = 1'b0;
				fault_act_nxt = 1'b0;
			end
			if (hi_fault) begin
				flag_h_nxt = 1'b1;
				fault_act_nxt = 1'b1;
			end
			if (lo_fault) begin
				flag_l_nxt = 1'b1;
				fault_act_nxt = 1'b1;
			end
		end
	end

	// Flag registers run whatever the pin function
	// The pin function only picks what drives the pin
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			flag_h_r <= 1'b0;
			flag_l_r <= 1'b0;
			fault_act_r <= 1'b0;
		end else begin
			flag_h_r <= flag_h_nxt;
			flag_l_r <= flag_l_nxt;
			fault_act_r <= fault_act_nxt;
		end
	end

	// Pin functions two and three count every published conversion of either
	// channel; dropped conversions are not counted. A new pulse that falls due
	// while one is running restarts the full pulse length.
	// Conversion-event pulses
	logic [1:0] conv_cnt_r; // Published conversions modulo four
	logic [7:0] pulse_cnt_r; // Remaining pulse cycles
	wire [1:0] conv_cnt_inc = conv_cnt_r + 2'h1;
	wire pulse_due = publish & ((pin_function == PIN_EOC)
		| ((pin_function == PIN_PAIR) & conv_cnt_inc[0] == 1'b0)
		| ((pin_function == PIN_QUAD) & conv_cnt_inc == 2'h0));

	// Count conversions and time the pulse
	// The conversion counter is cleared only by reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			conv_cnt_r <= 2'h0;
			pulse_cnt_r <= 8'h00;
		end else begin
			if (publish) begin
				conv_cnt_r <= conv_cnt_inc;
			end
			if (pulse_due) begin
				pulse_cnt_r <= 8'(PULSE_CYC);
			end else if (pulse_cnt_r != 8'h00) begin
				pulse_cnt_r <= pulse_cnt_r - 8'h01;
			end
		end
	end

	// The pin is open drain: its data is always low and only the enable moves.
	// A released pin floats to its pull-up level, so the enable is the inverse
	// of the wanted level. Shared lines then form a wired function.
	// Pin activity and open-drain drive
	wire pin_active = (pin_function == PIN_FAULT) ? fault_act_nxt
		: pulse_due | (pulse_cnt_r > 8'h01);
	wire pin_level = pin_active ? irq_pin_polarity : ~irq_pin_polarity;

	// Output registers
	// Every output leaves from a flop so nothing combinational reaches a pin
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			irq_out <= 1'b0;
			irq_oe <= 1'b0;
			restart_req <= 1'b0;
			result_valid <= 1'b0;
			result <= '0;
		end else begin
			irq_out <= 1'b0;
			irq_oe <= ~pin_level;
			restart_req <= abort;
			result_valid <= publish;
			if (publish) begin
				result <= '{ch: meas_s2_r.ch, expo: cur_exp, mant: pub_mant};
			end
		end
	end

	assign flag_high = flag_h_r;
	assign flag_low = flag_l_r;
	assign visible_channel_exp = vis_exp_r;
	assign infrared_channel_exp = ir_exp_r;
endmodule : lsira_core
